// [core/sfem_pkg.sv]
/*
 * Shared constants and carrier types for the E&M / single-frequency
 * signaling timer: clock rate, interval lengths, state codes, and the
 * transmit and receive output bundles.
 * Assumes one 50 MHz core clock; all intervals are counted in 1 ms ticks.
 */
`default_nettype none

package sfem_pkg;

    // ------------------------------------------------------------------
    // Clock and tick
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ    = 50_000_000;
    localparam int unsigned TICK_MS   = 1;
    localparam int unsigned MS_CYCLES = (CLK_HZ / 1000) * TICK_MS;

    localparam int MS_W = 10;
    typedef logic [MS_W-1:0] sfem_ms_t;
    localparam sfem_ms_t MS_MAX = 10'h3FF;

    // ------------------------------------------------------------------
    // Intervals in ms (nominal values)
    // ------------------------------------------------------------------
    localparam sfem_ms_t M_DELAY_MS     = 10'h012; // 18 ms
    localparam sfem_ms_t MIN_BURST_MS   = 10'h032; // 50 ms
    localparam sfem_ms_t HI_LEVEL_MS    = 10'h190; // 400 ms
    localparam sfem_ms_t CUT_REL_MS     = 10'h07D; // 125 ms
    localparam sfem_ms_t GUARD_HL_MS    = 10'h0E1; // 225 ms
    localparam sfem_ms_t GUARD_LH_MS    = 10'h032; // 50 ms
    localparam sfem_ms_t BSF_INS_MS     = 10'h00D; // 13 ms
    localparam sfem_ms_t BSF_MIN_MS     = 10'h0E1; // 225 ms
    localparam sfem_ms_t BSF_HANG_MS    = 10'h032; // 50 ms
    localparam sfem_ms_t SEIZE_MS       = 10'h032; // 50 ms
    localparam sfem_ms_t RELEASE_MS     = 10'h05A; // 90 ms
    localparam sfem_ms_t PULSE_RECOG_MS = 10'h00A; // 10 ms
    localparam sfem_ms_t BRK_8PPS_MS    = 10'h047; // 71 ms = 57% of 125
    localparam sfem_ms_t BRK_10PPS_MS   = 10'h03A; // 58 ms = 58% of 100
    localparam sfem_ms_t BRK_12PPS_MS   = 10'h031; // 49 ms = 59% of 83.3

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [1:0] PPS_8  = 2'h0;
    localparam logic [1:0] PPS_10 = 2'h1;
    localparam logic [1:0] PPS_12 = 2'h2;

    typedef enum logic [1:0] {
        TX_OFF  = 2'b00,
        TX_ARM  = 2'b01,
        TX_ON   = 2'b10,
        TX_HOLD = 2'b11
    } sfem_tx_e;

    typedef enum logic [1:0] {
        E_OPEN = 2'b00,
        E_GND  = 2'b01,
        E_BRK  = 2'b10,
        E_LONG = 2'b11
    } sfem_e_e;

    typedef struct packed {
        logic tone_on;
        logic tone_high;
        logic path_cut;
    } sfem_tx_s;

    typedef struct packed {
        logic band_stop_insert;
        logic e_lead_ground;
        logic guard_high;
    } sfem_rx_s;

    // Idle at power-up: tone on at low level, path cut, filter in, E open
    localparam sfem_tx_s TX_RST = 3'b101;
    localparam sfem_rx_s RX_RST = 3'b101;

    function automatic sfem_ms_t sat_inc(input sfem_ms_t v);
        sat_inc = (v == MS_MAX) ? v : v + 10'h001;
    endfunction : sat_inc

endpackage : sfem_pkg

`default_nettype wire

// [core/sfem_signal_timer.sv]
/*
 * E&M lead to single-frequency tone signaling timer, both directions.
 * Assumes M-lead sense inputs and detector outputs are already
 * synchronous to i_core_clk; analog tone and guard detection are outside.
 */
// How it works
// (R1) Tone is sent while idle, withheld while busy, and sent only in breaks while dialing.
// (R2) Each recognised off-hook to on-hook change sends high-level tone for 400 ms.
// (R3) In normal mode the trunk signals idle with open or ground and busy with battery.
// (R4) In inverted mode battery or open means idle and ground means busy.
// (R5) The tone state follows an M-lead change after 18 ms.
// (R6) On-hook intervals shorter than the M-lead delay are ignored.
// (R7) A recognised break of up to 50 ms is stretched to a 50 ms burst.
// (R8) A longer break is sent as a burst of the same length.
// (R9) The transmit speech path is cut 18 ms before tone starts.
// (R10) The path cut is removed 125 ms after off-hook is detected.
// (R11) Guard goes high to low after 225 ms and low to high after 50 ms.
// (R12) The band-stop filter goes in 13 ms after tone and stays 225 ms for short tones.
// (R13) For long tones the filter stays for tone length plus 50 ms.
// (R14) The E lead is grounded 50 ms after tone disappears.
// (R15) The E lead is opened 90 ms after tone reappears.
// (R16) Repeated pulses get a 57, 58 or 59 percent break at 8, 10 or 12 pps.
// (R17) Intervals are measured by counting a fixed 1 ms tick from sync inputs.
`timescale 1ns/1ps
`default_nettype none

module sfem_signal_timer #(
    parameter int unsigned TICK_CYCLES = sfem_pkg::MS_CYCLES
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_m_batt,
    input  wire logic             i_m_gnd,
    input  wire logic             i_m_lead_invert_select,
    input  wire logic             i_tone_present,
    input  wire logic             i_guard_raw,
    input  wire logic [1:0]       i_pulse_rate_sel,
    output var  sfem_pkg::sfem_tx_s o_tx,
    output var  sfem_pkg::sfem_rx_s o_rx
);
    import sfem_pkg::*;

    // ------------------------------------------------------------------
    // Tick
    // ------------------------------------------------------------------
    logic tick;

    sfem_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .o_tick     (tick)
    );

    // ------------------------------------------------------------------
    // Transmit: M lead to tone
    // ------------------------------------------------------------------
    sfem_tx_e tx_st_ff;
    sfem_tx_e nxt_tx_st;
    sfem_ms_t del_ff;
    sfem_ms_t burst_ff;
    sfem_ms_t hi_ff;
    sfem_ms_t rel_ff;
    logic     cut_ff;
    logic     m_busy;

    assign m_busy = i_m_lead_invert_select ? i_m_gnd : i_m_batt; // R3 R4

    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        if (tick)
        begin
            unique case (tx_st_ff)
                TX_OFF:
                    if (!m_busy)
                        nxt_tx_st = TX_ARM;
                TX_ARM:
                    if (m_busy)
                        nxt_tx_st = TX_OFF; // R6
                    else if (del_ff >= M_DELAY_MS - 10'h001)
                        nxt_tx_st = TX_ON; // R5
                TX_ON:
                    if (m_busy)
                        nxt_tx_st = TX_HOLD;
                TX_HOLD:
                    if (!m_busy)
                        nxt_tx_st = TX_ON;
                    else if (del_ff >= M_DELAY_MS - 10'h001
                             && burst_ff >= MIN_BURST_MS - 10'h001)
                        nxt_tx_st = TX_OFF; // R7 R8
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            tx_st_ff <= TX_ON;
        else
            tx_st_ff <= nxt_tx_st;
    end

    // Delay counter restarts on every entry to a timed state
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            del_ff <= '0;
        else if (tick)
            del_ff <= (nxt_tx_st != tx_st_ff) ? '0 : sat_inc(del_ff); // R5
    end

    // Burst length since onset; preset to MS_MAX at reset, so only the power-up tone can drop before 50 ms
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            burst_ff <= MS_MAX;
        else if (tick && tx_st_ff == TX_ARM && nxt_tx_st == TX_ON)
            burst_ff <= '0; // R7
        else if (tick && (tx_st_ff == TX_ON || tx_st_ff == TX_HOLD))
            burst_ff <= sat_inc(burst_ff);
    end

    // High-level window; power-up idle starts at low level
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            hi_ff <= MS_MAX;
        else if (tick && tx_st_ff == TX_ARM && nxt_tx_st == TX_ON)
            hi_ff <= '0; // R2
        else if (tick)
            hi_ff <= sat_inc(hi_ff);
    end

    // Path cut: opens with the recognition timer so it leads tone by 18 ms
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rel_ff <= '0;
        else if (tick)
            rel_ff <= m_busy ? sat_inc(rel_ff) : '0;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cut_ff <= 1'b1;
        else if (tick && tx_st_ff == TX_OFF && !m_busy)
            cut_ff <= 1'b1; // R9
        else if (tick && m_busy && tx_st_ff == TX_OFF
                 && rel_ff == CUT_REL_MS - 10'h001)
            cut_ff <= 1'b0; // R10
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_tx <= TX_RST;
        else
        begin
            o_tx.tone_on   <= (tx_st_ff == TX_ON) || (tx_st_ff == TX_HOLD); // R1
            o_tx.tone_high <= ((tx_st_ff == TX_ON) || (tx_st_ff == TX_HOLD))
                              && (hi_ff < HI_LEVEL_MS); // R2
            o_tx.path_cut  <= cut_ff;
        end
    end

    // ------------------------------------------------------------------
    // Receive: guard and band-stop timing
    // ------------------------------------------------------------------
    sfem_ms_t gcnt_ff;
    logic     guard_ff;
    logic     tone_prev_ff;
    sfem_ms_t arr_ff;
    sfem_ms_t hang_ff;
    logic     bsf_ff;
    logic     tone_rise;

    assign tone_rise = i_tone_present && !tone_prev_ff;

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            gcnt_ff  <= '0;
            guard_ff <= 1'b1;
        end
        else if (tick)
        begin
            if (i_guard_raw == guard_ff)
                gcnt_ff <= '0;
            else if (gcnt_ff >= (guard_ff ? GUARD_HL_MS : GUARD_LH_MS)
                                - 10'h001)
            begin
                guard_ff <= i_guard_raw; // R11
                gcnt_ff  <= '0;
            end
            else
                gcnt_ff <= sat_inc(gcnt_ff);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            tone_prev_ff <= 1'b1;
        else if (tick)
            tone_prev_ff <= i_tone_present;
    end

    // Time since tone arrival, kept running while the filter is in
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            arr_ff <= MS_MAX;
        else if (tick && tone_rise)
            arr_ff <= '0;
        else if (tick && (i_tone_present || bsf_ff))
            arr_ff <= sat_inc(arr_ff);
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            hang_ff <= '0;
        else if (tick)
            hang_ff <= i_tone_present ? '0 : sat_inc(hang_ff);
    end

    // Short tones hold for 225 ms from arrival, long ones for tone + 50 ms
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            bsf_ff <= 1'b1;
        else if (tick && !bsf_ff && i_tone_present && !tone_rise
                 && arr_ff >= BSF_INS_MS - 10'h001)
            bsf_ff <= 1'b1; // R12
        else if (tick && bsf_ff && !i_tone_present
                 && hang_ff >= BSF_HANG_MS - 10'h001
                 && arr_ff >= BSF_MIN_MS - 10'h001)
            bsf_ff <= 1'b0; // R12 R13
    end

    // ------------------------------------------------------------------
    // Receive: E lead with pulse correction
    // ------------------------------------------------------------------
    sfem_e_e  e_st_ff;
    sfem_e_e  nxt_e_st;
    sfem_ms_t ecnt_ff;
    sfem_ms_t brk_len;

    always_comb
    begin
        unique case (i_pulse_rate_sel)
            PPS_8:   brk_len = BRK_8PPS_MS;
            PPS_12:  brk_len = BRK_12PPS_MS;
            default: brk_len = BRK_10PPS_MS;
        endcase
    end

    always_comb
    begin
        nxt_e_st = e_st_ff;
        if (tick)
        begin
            unique case (e_st_ff)
                E_OPEN:
                    if (!i_tone_present && ecnt_ff >= SEIZE_MS - 10'h001)
                        nxt_e_st = E_GND; // R14
                E_GND:
                    if (i_tone_present && ecnt_ff >= PULSE_RECOG_MS - 10'h001)
                        nxt_e_st = E_BRK;
                E_BRK:
                    if (ecnt_ff >= brk_len - 10'h001)
                        nxt_e_st = i_tone_present ? E_LONG : E_GND; // R16
                E_LONG:
                    if (!i_tone_present)
                        nxt_e_st = E_GND;
                    else if (arr_ff >= RELEASE_MS - 10'h001)
                        nxt_e_st = E_OPEN; // R15
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            e_st_ff <= E_OPEN;
        else
            e_st_ff <= nxt_e_st;
    end

    // Counts tone absence, tone presence, or break time, per state
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            ecnt_ff <= '0;
        else if (tick)
        begin
            if (nxt_e_st != e_st_ff)
                ecnt_ff <= '0;
            else if (e_st_ff == E_BRK)
                ecnt_ff <= sat_inc(ecnt_ff); // R16
            else if ((e_st_ff == E_OPEN) != i_tone_present)
                ecnt_ff <= sat_inc(ecnt_ff);
            else
                ecnt_ff <= '0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_rx <= RX_RST;
        else
        begin
            o_rx.band_stop_insert <= bsf_ff;
            o_rx.e_lead_ground    <= (e_st_ff == E_GND);
            o_rx.guard_high       <= guard_ff;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    short_break_a : assert property ( // R6
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (tick && tx_st_ff == TX_ARM && m_busy) |=> ##1 !o_tx.tone_on)
        else $error("short break produced tone");

    tone_onset_a : assert property ( // R5
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (tx_st_ff == TX_ON && $past(tx_st_ff) == TX_ARM)
        |-> $past(del_ff) == M_DELAY_MS - 10'h001 ##1 o_tx.tone_on)
        else $error("tone onset not at M-lead delay");

    burst_min_a : assert property ( // R7
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (tx_st_ff == TX_OFF && $past(tx_st_ff) == TX_HOLD)
        |-> $past(burst_ff) >= MIN_BURST_MS - 10'h001)
        else $error("tone burst shorter than minimum");

    burst_end_a : assert property ( // R8
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (tx_st_ff == TX_OFF && $past(tx_st_ff) == TX_HOLD)
        |-> $past(del_ff) >= M_DELAY_MS - 10'h001 && $past(m_busy))
        else $error("tone ended before make was recognised");

    high_level_a : assert property ( // R2
        @(posedge i_core_clk) disable iff (!i_arst_n)
        o_tx.tone_high |-> o_tx.tone_on && $past(hi_ff) < HI_LEVEL_MS)
        else $error("high level outside its window");

    cut_lead_a : assert property ( // R9
        @(posedge i_core_clk) disable iff (!i_arst_n)
        $rose(o_tx.tone_on) |-> o_tx.path_cut && $past(o_tx.path_cut))
        else $error("tone started with speech path closed");

    cut_release_a : assert property ( // R10
        @(posedge i_core_clk) disable iff (!i_arst_n)
        $fell(cut_ff) |-> $past(rel_ff) == CUT_REL_MS - 10'h001
                          && $past(m_busy))
        else $error("path cut removed at wrong time");

    guard_time_a : assert property ( // R11
        @(posedge i_core_clk) disable iff (!i_arst_n)
        $changed(guard_ff) |-> $past(gcnt_ff) ==
            ($past(guard_ff) ? GUARD_HL_MS : GUARD_LH_MS) - 10'h001)
        else $error("guard moved at wrong time");

    bsf_insert_a : assert property ( // R12
        @(posedge i_core_clk) disable iff (!i_arst_n)
        $rose(bsf_ff) |-> $past(arr_ff) >= BSF_INS_MS - 10'h001
                          && $past(i_tone_present))
        else $error("band-stop inserted early");

    bsf_hang_a : assert property ( // R13
        @(posedge i_core_clk) disable iff (!i_arst_n)
        $fell(bsf_ff) |-> $past(hang_ff) >= BSF_HANG_MS - 10'h001
                          && $past(arr_ff) >= BSF_MIN_MS - 10'h001)
        else $error("band-stop removed before hangover");

    seize_time_a : assert property ( // R14
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (e_st_ff == E_GND && $past(e_st_ff) == E_OPEN)
        |-> $past(ecnt_ff) == SEIZE_MS - 10'h001 ##1 o_rx.e_lead_ground)
        else $error("seizure at wrong delay");

    release_time_a : assert property ( // R15
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (e_st_ff == E_OPEN && $past(e_st_ff) == E_LONG)
        |-> $past(arr_ff) == RELEASE_MS - 10'h001)
        else $error("release at wrong delay");

    pulse_break_a : assert property ( // R16
        @(posedge i_core_clk) disable iff (!i_arst_n)
        ($past(e_st_ff) == E_BRK && e_st_ff != E_BRK)
        |-> $past(ecnt_ff) == $past(brk_len) - 10'h001)
        else $error("corrected break length wrong");

endmodule : sfem_signal_timer

`default_nettype wire

// [core/sfem_tick_gen.sv]
/*
 * Divider producing a one-cycle enable every TICK_CYCLES core clocks.
 * Assumes a free-running core clock and asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sfem_tick_gen #(
    parameter int unsigned TICK_CYCLES = sfem_pkg::MS_CYCLES
) (
    input  wire logic i_core_clk,
    input  wire logic i_arst_n,
    output var  logic o_tick
);
    import sfem_pkg::*;

    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] div_ff;

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            div_ff <= '0;
            o_tick <= 1'b0;
        end
        else
        begin
            o_tick <= (div_ff == LAST); // R17
            div_ff <= (div_ff == LAST) ? '0 : div_ff + CW'(1);
        end
    end

    tick_period_a : assert property ( // R17
        @(posedge i_core_clk) disable iff (!i_arst_n)
        o_tick |=> !o_tick || (TICK_CYCLES == 1))
        else $error("tick pulse longer than one cycle");

endmodule : sfem_tick_gen

`default_nettype wire

// [verif/sfem_signal_timer_bench.sv]
/*
 * Self-checking bench for the signaling timer, tick shortened to 4 clocks.
 * Assumes the trunk model in its own file; times are measured in ticks.
 */
`timescale 1ns/1ps
`default_nettype none

module sfem_signal_timer_bench;
    import sfem_pkg::*;
    localparam int TK    = 4;
    localparam int LIMIT = 60000;

    logic               clk       = 1'b0;
    logic               arst_n    = 1'b0;
    logic               m_busy    = 1'b0;
    logic               m_open    = 1'b0;
    logic               m_invert  = 1'b0;
    logic               tone_cmd  = 1'b1;
    logic               guard     = 1'b1;
    logic [1:0]         pulse_sel = 2'h1;
    logic               m_batt;
    logic               m_gnd;
    logic               tone;
    sfem_tx_s           tx;
    sfem_rx_s           rx;
    logic [5:0]         outs;
    int                 bad_count = 0;
    int                 checks    = 0;
    int                 cyc       = 0;

    // Bits: tone_on tone_high path_cut band_stop e_ground guard_high
    assign outs = {tx, rx};

    initial
    begin
        forever #10 clk = ~clk;
    end

    sfem_trunk_model far (
        .i_core_clk (clk),
        .i_arst_n   (arst_n),
        .i_busy     (m_busy),
        .i_open     (m_open),
        .i_invert   (m_invert),
        .i_tone_cmd (tone_cmd),
        .o_m_batt   (m_batt),
        .o_m_gnd    (m_gnd),
        .o_tone     (tone)
    );

    sfem_signal_timer #(.TICK_CYCLES(TK)) dut (
        .i_core_clk             (clk),
        .i_arst_n               (arst_n),
        .i_m_batt               (m_batt),
        .i_m_gnd                (m_gnd),
        .i_m_lead_invert_select (m_invert),
        .i_tone_present         (tone),
        .i_guard_raw            (guard),
        .i_pulse_rate_sel       (pulse_sel),
        .o_tx                   (tx),
        .o_rx                   (rx)
    );

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // Tolerance covers tick quantisation plus register lag
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input int tol);
        int d;
        d = int'(seen) - int'(exp);
        checks++;
        if ((^seen === 1'bx) || d > tol || d < -tol)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Returns elapsed ticks; equals lim when the level never came
    task automatic wait_bit(input int sel, input logic val, input int lim,
                            output logic [15:0] ms);
        int n;
        n = 0;
        while (outs[sel] !== val && n < lim * TK)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        ms = 16'(n / TK);
    endtask : wait_bit

    task automatic idle(input int n);
        repeat (n * TK) @(posedge clk);
        #1;
    endtask : idle

    // ------------------------------------------------------------------
    // Transmit scenarios
    // ------------------------------------------------------------------
    task automatic t_busy();
        logic [15:0] ms;
        @(posedge clk);
        m_busy <= 1'b1;
        wait_bit(5, 1'b0, 100, ms);
        check(ms, 16'd18, 2);
        wait_bit(3, 1'b0, 300, ms);
        check(ms, 16'd107, 2);
    endtask : t_busy

    task automatic t_idle();
        logic [15:0] ms;
        @(posedge clk);
        m_busy <= 1'b0;
        m_open <= 1'b1;
        wait_bit(3, 1'b1, 10, ms);
        check(ms, 16'd0, 2);
        wait_bit(5, 1'b1, 40, ms);
        check(ms, 16'd18, 2);
        check(16'(outs[4]), 16'd1, 0);
        wait_bit(4, 1'b0, 600, ms);
        check(ms, 16'd400, 2);
        @(posedge clk);
        m_open <= 1'b0;
        idle(30);
        check(16'(outs[5]), 16'd1, 0);
        t_busy();
        idle(100);
    endtask : t_idle

    // Break of len ticks from busy; dur 0 means no tone expected
    task automatic t_break(input int len, input int dur);
        logic [15:0] ms;
        @(posedge clk);
        m_busy <= 1'b0;
        fork
            begin
                repeat (len * TK) @(posedge clk);
                m_busy <= 1'b1;
            end
            begin
                wait_bit(5, 1'b1, 80, ms);
                if (dur == 0)
                    check(ms, 16'd80, 0);
                else
                begin
                    check(ms, 16'd18, 2);
                    wait_bit(5, 1'b0, 200, ms);
                    check(ms, 16'(dur), 2);
                end
            end
        join
        idle(200);
    endtask : t_break

    task automatic t_invert();
        logic [15:0] ms;
        @(posedge clk);
        m_invert <= 1'b1;
        idle(30);
        check(16'(outs[5]), 16'd0, 0);
        @(posedge clk);
        m_busy <= 1'b0;
        wait_bit(5, 1'b1, 40, ms);
        check(ms, 16'd18, 2);
        idle(100);
        t_busy();
        @(posedge clk);
        m_invert <= 1'b0;
        idle(100);
    endtask : t_invert

    // ------------------------------------------------------------------
    // Receive scenarios
    // ------------------------------------------------------------------
    task automatic t_long();
        logic [15:0] ms;
        @(posedge clk);
        tone_cmd <= 1'b0;
        wait_bit(1, 1'b1, 100, ms);
        check(ms, 16'd50, 2);
        idle(300);
        check(16'(outs[2]), 16'd0, 0);
        @(posedge clk);
        tone_cmd <= 1'b1;
        wait_bit(2, 1'b1, 40, ms);
        check(ms, 16'd13, 2);
        idle(187);
        check(16'(outs[1]), 16'd0, 0);
        @(posedge clk);
        tone_cmd <= 1'b0;
        wait_bit(1, 1'b1, 100, ms);
        check(ms, 16'd50, 2);
        wait_bit(2, 1'b0, 100, ms);
        check(ms, 16'd0, 2);
        idle(300);
    endtask : t_long

    task automatic t_pulse(input logic [1:0] rate, input int brk);
        logic [15:0] ms;
        logic [15:0] fs;
        @(posedge clk);
        pulse_sel <= rate;
        tone_cmd  <= 1'b1;
        fork
            begin
                idle(40);
                @(posedge clk);
                tone_cmd <= 1'b0;
            end
            begin
                wait_bit(1, 1'b0, 30, ms);
                check(ms, 16'd10, 2);
                wait_bit(1, 1'b1, 150, ms);
                check(ms, 16'(brk), 2);
            end
            begin
                wait_bit(2, 1'b1, 30, fs);
                check(fs, 16'd13, 2);
                wait_bit(2, 1'b0, 300, fs);
                check(fs, 16'd212, 3);
            end
        join
        idle(100);
    endtask : t_pulse

    task automatic t_guard();
        logic [15:0] ms;
        @(posedge clk);
        guard <= 1'b0;
        wait_bit(0, 1'b0, 300, ms);
        check(ms, 16'd225, 2);
        @(posedge clk);
        guard <= 1'b1;
        wait_bit(0, 1'b1, 100, ms);
        check(ms, 16'd50, 2);
    endtask : t_guard

    // ------------------------------------------------------------------
    // Sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        check(16'(outs), 16'h002D, 0);
        idle(20);
        t_busy();
        idle(100);
        t_idle();
        t_break(10, 0);
        t_break(30, 50);
        t_break(100, 100);
        t_invert();
        t_long();
        t_pulse(PPS_8, 71);
        t_pulse(PPS_10, 58);
        t_pulse(PPS_12, 49);
        t_pulse(2'h3, 58);
        t_guard();
        give_verdict();
    end
endmodule : sfem_signal_timer_bench

`default_nettype wire

// [verif/sfem_trunk_model.sv]
/*
 * Behavioural far side: the trunk's M-lead driver and the facility tone.
 * Assumes bench commands change just after a rising edge of the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sfem_trunk_model (
    input  wire logic i_core_clk,
    input  wire logic i_arst_n,
    input  wire logic i_busy,
    input  wire logic i_open,
    input  wire logic i_invert,
    input  wire logic i_tone_cmd,
    output var  logic o_m_batt,
    output var  logic o_m_gnd,
    output var  logic o_tone
);
    // ------------------------------------------------------------------
    // M lead: idle trunk at ground out of reset
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_m_batt <= 1'b0;
            o_m_gnd  <= 1'b1;
        end
        else if (i_invert)
        begin
            o_m_gnd  <= i_busy;
            o_m_batt <= !i_busy && !i_open;
        end
        else
        begin
            o_m_batt <= i_busy;
            o_m_gnd  <= !i_busy && !i_open;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_tone <= 1'b1;
        else
            o_tone <= i_tone_cmd;
    end
endmodule : sfem_trunk_model

`default_nettype wire
